// ===== rtl/tsca_pkg.sv
// Package: constants for the temperature sensor configuration and alarm block
package tsca_pkg;
   // ****************************************************
   // Register addressing
   // ****************************************************
   localparam logic [1:0] PTR_CONFIG = 2'h1;
   localparam logic [1:0] PTR_MASK = 2'h3;
   // ****************************************************
   // Field positions in the 16-bit configuration word
   // ****************************************************
   localparam int BIT_ONESHOT = 15;
   localparam int BIT_RES_HI = 14;
   localparam int BIT_RES_LO = 13;
   localparam int BIT_FAULT_HI = 12;
   localparam int BIT_FAULT_LO = 11;
   localparam int BIT_POL = 10;
   localparam int BIT_STYLE = 9;
   localparam int BIT_SHUTDOWN = 8;
   localparam int BIT_RATE_HI = 7;
   localparam int BIT_RATE_LO = 6;
   localparam int BIT_ALARM = 5;
   localparam int BIT_EXTEND = 4;
   // ****************************************************
   // Reset values
   // ****************************************************
   localparam logic [1:0] RATE_RESET = 2'h2;
   localparam logic [1:0] FAULT_RESET = 2'h0;
   localparam logic [1:0] RES_READ = 2'h3;
   // ****************************************************
   // Fault counts and conversion periods
   // ****************************************************
   localparam logic [2:0] FAULTS_1 = 3'h1;
   localparam logic [2:0] FAULTS_2 = 3'h2;
   localparam logic [2:0] FAULTS_4 = 3'h4;
   localparam logic [2:0] FAULTS_6 = 3'h6;
   localparam int CLK_HZ = 20_000_000;
   localparam int PERIOD_025_MS = 4000;
   localparam int PERIOD_1_MS = 1000;
   localparam int PERIOD_4_MS = 250;
   localparam int PERIOD_8_MS = 125;
   localparam int CYC_025 = PERIOD_025_MS * (CLK_HZ / 1000);
   localparam int CYC_1 = PERIOD_1_MS * (CLK_HZ / 1000);
   localparam int CYC_4 = PERIOD_4_MS * (CLK_HZ / 1000);
   localparam int CYC_8 = PERIOD_8_MS * (CLK_HZ / 1000);
   localparam int TEMP_W = 13;
endpackage

// ===== rtl/tsca_fault_filter.sv
// Module: consecutive fault counter with comparator-style alarm state
`timescale 1ns/100ps
`default_nettype none
module tsca_fault_filter
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic sample_i,
   input wire logic over_i,
   input wire logic under_i,
   input wire logic [2:0] need_i,
   output logic alarm_o
);
   logic alarm_reg;
   logic alarm_next;
   logic [2:0] count_reg;
   logic [2:0] count_next;

   always_comb
   begin
      alarm_next = alarm_reg;
      count_next = count_reg;
      if (sample_i)
      begin
         // Count only results that argue for leaving the current state
         if ((!alarm_reg && over_i) || (alarm_reg && under_i))
         begin
            if (count_reg + 3'h1 >= need_i)
            begin
               alarm_next = !alarm_reg; // RULE_03 RULE_04
               count_next = 3'h0;
            end
            else
            begin
               count_next = count_reg + 3'h1; // RULE_07
            end
         end
         else
         begin
            count_next = 3'h0;
         end
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         alarm_reg <= 1'b0;
         count_reg <= 3'h0;
      end
      else
      begin
         alarm_reg <= alarm_next;
         count_reg <= count_next;
      end
   end

   assign alarm_o = alarm_reg;
endmodule
`default_nettype wire

// ===== rtl/tsca_config_alarm.sv
// Module: configuration register and alarm status of the temperature sensor
`timescale 1ns/100ps
`default_nettype none
// Contract
// RULE_01: Configuration bit 8 set to 1 stops conversions; 0, the reset value, converts.
// RULE_02: The rate field picks 0.25, 1, 4 or 8 Hz conversions and resets to 4 Hz.
// RULE_03: With polarity 0 the alarm status resets to 1 and drops to 0 after enough hot results.
// RULE_04: Once 0 it returns to 1 after enough consecutive results below the lower limit.
// RULE_05: With polarity 1 the alarm status is the inverse of the polarity 0 behaviour.
// RULE_06: The output style select does not change the alarm status hysteresis.
// RULE_07: The fault field needs one, two, four or six consecutive results.
// RULE_08: The range extension select picks 12-bit or 13-bit format and resets to 0.
// RULE_09: Pointer value 01 reaches the 16-bit configuration word, high byte first.
// RULE_10: The alert output is active high with polarity 1 and active low with polarity 0.
// RULE_11: The four lowest configuration bits ignore writes and read as zero.
module tsca_config_alarm
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic [1:0] pointer_i,
   input wire logic byte_wr_i,
   input wire logic byte_rd_i,
   input wire logic byte_first_i,
   input wire logic [7:0] wr_byte_i,
   output logic [7:0] rd_byte_o,
   input wire logic result_valid_i,
   input wire logic signed [12:0] temp_i,
   input wire logic signed [12:0] upper_limit_i,
   input wire logic signed [12:0] lower_limit_i,
   input wire logic converting_i,
   output logic shutdown_select_o,
   output logic convert_start_o,
   output logic range_extend_select_o,
   output logic output_style_select_o,
   output logic alert_o
);
   // ****************************************************
   // Configuration state
   // ****************************************************
   logic shutdown_reg;
   logic shutdown_next;
   logic [1:0] rate_reg;
   logic [1:0] rate_next;
   logic [1:0] fault_reg;
   logic [1:0] fault_next;
   logic pol_reg;
   logic pol_next;
   logic style_reg;
   logic style_next;
   logic extend_reg;
   logic extend_next;
   logic second_reg;
   logic second_next;
   logic [7:0] rd_reg;
   logic [7:0] rd_next;
   logic [27:0] tick_reg;
   logic [27:0] tick_next;
   logic start_reg;
   logic start_next;
   logic [15:0] config_word;
   logic [27:0] period;
   logic [2:0] need;
   logic raw_alarm;
   logic alarm_status;
   logic hot;
   logic cold;

   // ****************************************************
   // Readback word
   // ****************************************************
   // Idle reads as inverse of polarity, tripped reads as polarity
   assign alarm_status = raw_alarm ? pol_reg : !pol_reg; // RULE_03 RULE_05
   always_comb
   begin
      config_word = 16'h0000; // RULE_11
      config_word[tsca_pkg::BIT_ONESHOT] = !converting_i;
      config_word[tsca_pkg::BIT_RES_HI] = tsca_pkg::RES_READ[1];
      config_word[tsca_pkg::BIT_RES_LO] = tsca_pkg::RES_READ[0];
      config_word[tsca_pkg::BIT_FAULT_HI] = fault_reg[1];
      config_word[tsca_pkg::BIT_FAULT_LO] = fault_reg[0];
      config_word[tsca_pkg::BIT_POL] = pol_reg;
      config_word[tsca_pkg::BIT_STYLE] = style_reg;
      config_word[tsca_pkg::BIT_SHUTDOWN] = shutdown_reg;
      config_word[tsca_pkg::BIT_RATE_HI] = rate_reg[1];
      config_word[tsca_pkg::BIT_RATE_LO] = rate_reg[0];
      config_word[tsca_pkg::BIT_ALARM] = alarm_status;
      config_word[tsca_pkg::BIT_EXTEND] = extend_reg;
   end

   // ****************************************************
   // Register access
   // ****************************************************
   always_comb
   begin
      shutdown_next = shutdown_reg;
      rate_next = rate_reg;
      fault_next = fault_reg;
      pol_next = pol_reg;
      style_next = style_reg;
      extend_next = extend_reg;
      second_next = second_reg;
      rd_next = rd_reg;
      if ((byte_wr_i || byte_rd_i) && pointer_i == tsca_pkg::PTR_CONFIG) // RULE_09
      begin
         if (byte_first_i)
         begin
            second_next = 1'b1;
         end
         else
         begin
            second_next = !second_reg;
         end
         if (byte_rd_i)
         begin
            rd_next = (byte_first_i || !second_reg) ? config_word[15:8] : config_word[7:0]; // RULE_09
         end
         else if (byte_first_i || !second_reg)
         begin
            fault_next = wr_byte_i[4:3]; // RULE_07
            pol_next = wr_byte_i[2]; // RULE_10
            style_next = wr_byte_i[1]; // RULE_06
            shutdown_next = wr_byte_i[0]; // RULE_01
         end
         else
         begin
            rate_next = wr_byte_i[7:6]; // RULE_02
            extend_next = wr_byte_i[4]; // RULE_08
         end
      end
   end

   // ****************************************************
   // Conversion pacing
   // ****************************************************
   always_comb
   begin
      case (rate_reg)
         2'h0: period = 28'(tsca_pkg::CYC_025);
         2'h1: period = 28'(tsca_pkg::CYC_1);
         2'h2: period = 28'(tsca_pkg::CYC_4);
         default: period = 28'(tsca_pkg::CYC_8);
      endcase
      tick_next = tick_reg + 28'h000_0001;
      start_next = 1'b0;
      if (shutdown_reg) // RULE_01
      begin
         tick_next = 28'h000_0000;
      end
      else if (tick_reg + 28'h000_0001 >= period) // RULE_02
      begin
         tick_next = 28'h000_0000;
         start_next = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         shutdown_reg <= 1'b0;
         rate_reg <= tsca_pkg::RATE_RESET;
         fault_reg <= tsca_pkg::FAULT_RESET;
         pol_reg <= 1'b0;
         style_reg <= 1'b0;
         extend_reg <= 1'b0;
         second_reg <= 1'b0;
         rd_reg <= 8'h00;
         tick_reg <= 28'h000_0000;
         start_reg <= 1'b0;
      end
      else
      begin
         shutdown_reg <= shutdown_next;
         rate_reg <= rate_next;
         fault_reg <= fault_next;
         pol_reg <= pol_next;
         style_reg <= style_next;
         extend_reg <= extend_next;
         second_reg <= second_next;
         rd_reg <= rd_next;
         tick_reg <= tick_next;
         start_reg <= start_next;
      end
   end

   // ****************************************************
   // Alarm filtering
   // ****************************************************
   always_comb
   begin
      case (fault_reg)
         2'h0: need = tsca_pkg::FAULTS_1;
         2'h1: need = tsca_pkg::FAULTS_2;
         2'h2: need = tsca_pkg::FAULTS_4;
         default: need = tsca_pkg::FAULTS_6;
      endcase
   end

   assign hot = temp_i >= upper_limit_i; // RULE_03
   assign cold = temp_i < lower_limit_i; // RULE_04

   // Comparator hysteresis regardless of output style
   tsca_fault_filter u_filter
   (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .sample_i(result_valid_i),
      .over_i(hot),
      .under_i(cold),
      .need_i(need),
      .alarm_o(raw_alarm)
   ); // RULE_06

   assign rd_byte_o = rd_reg;
   assign shutdown_select_o = shutdown_reg;
   assign convert_start_o = start_reg;
   assign range_extend_select_o = extend_reg;
   assign output_style_select_o = style_reg;
   assign alert_o = raw_alarm ? pol_reg : !pol_reg; // RULE_10
endmodule
`default_nettype wire

// ===== sim/tsca_config_alarm_asserts.sv
// Checker: port properties of the config and alarm block
`timescale 1ns/100ps
`default_nettype none
module tsca_config_alarm_asserts
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic [1:0] pointer_i,
   input wire logic byte_wr_i,
   input wire logic byte_rd_i,
   input wire logic byte_first_i,
   input wire logic [7:0] wr_byte_i,
   input wire logic [7:0] rd_byte_o,
   input wire logic result_valid_i,
   input wire logic signed [12:0] temp_i,
   input wire logic signed [12:0] upper_limit_i,
   input wire logic signed [12:0] lower_limit_i,
   input wire logic shutdown_select_o,
   input wire logic convert_start_o,
   input wire logic range_extend_select_o,
   input wire logic output_style_select_o,
   input wire logic alert_o
);
   logic [7:0] hi_reg;
   logic [7:0] hi_next;
   logic cfg;
   logic hot;
   logic cold;
   assign cfg = pointer_i == 2'h1;
   assign hot = result_valid_i && temp_i >= upper_limit_i && hi_reg[4:3] == 2'h0;
   assign cold = result_valid_i && temp_i < lower_limit_i && hi_reg[4:3] == 2'h0;
   // Shadow of the written high byte
   always_comb
   begin
      hi_next = hi_reg;
      if (reset_i)
         hi_next = 8'h00;
      else if (byte_wr_i && byte_first_i && cfg)
         hi_next = wr_byte_i;
   end
   always_ff @(posedge clk_sys_i)
      hi_reg <= hi_next;
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (reset_i);
   shutdown_wr_a: assert property (byte_wr_i && byte_first_i && cfg
      |=> shutdown_select_o == $past(wr_byte_i[0])) else $error("shutdown not written");
   style_wr_a: assert property (byte_wr_i && byte_first_i && cfg
      |=> output_style_select_o == $past(wr_byte_i[1])) else $error("style not written");
   ptr_ignore_a: assert property (byte_wr_i && !cfg
      |=> $stable(shutdown_select_o) && $stable(output_style_select_o)) else $error("bad ptr");
   rst_val_a: assert property ($fell(reset_i) |-> rd_byte_o == 8'h00 && alert_o
      && !shutdown_select_o && !range_extend_select_o) else $error("reset values wrong");
   shut_quiet_a: assert property (shutdown_select_o && $past(shutdown_select_o)
      |-> !convert_start_o) else $error("conversion in shutdown");
   hot_trip_a: assert property (hot |=> alert_o == hi_reg[2]) else $error("no trip");
   cold_clear_a: assert property (cold |=> alert_o != hi_reg[2]) else $error("no clear");
   alert_hold_a: assert property (!result_valid_i && !byte_wr_i
      |=> $stable(alert_o)) else $error("alert moved");
   rd_hi_a: assert property (byte_rd_i && byte_first_i && cfg
      |=> rd_byte_o[6:0] == {2'h3, hi_reg[4:0]}) else $error("high byte wrong");
   rd_lo_a: assert property (byte_rd_i && !byte_first_i && cfg
      |=> rd_byte_o[3:0] == 4'h0) else $error("low nibble not zero");
endmodule
bind tsca_config_alarm tsca_config_alarm_asserts chk (.clk_sys_i, .reset_i, .pointer_i,
   .byte_wr_i, .byte_rd_i, .byte_first_i, .wr_byte_i, .rd_byte_o, .result_valid_i, .temp_i,
   .upper_limit_i, .lower_limit_i, .shutdown_select_o, .convert_start_o,
   .range_extend_select_o, .output_style_select_o, .alert_o);
`default_nettype wire

// ===== sim/tsca_host_model.sv
// Partner: serial host moving configuration bytes
`timescale 1ns/100ps
`default_nettype none
module tsca_host_model
(
   input wire logic clk_sys_i,
   input wire logic [7:0] rd_byte_i,
   output logic [1:0] pointer_o,
   output logic byte_wr_o,
   output logic byte_rd_o,
   output logic byte_first_o,
   output logic [7:0] wr_byte_o
);
   initial
   begin
      pointer_o = 2'h0;
      byte_wr_o = 1'b0;
      byte_rd_o = 1'b0;
      byte_first_o = 1'b0;
      wr_byte_o = 8'h00;
   end
   task automatic wr_word(input logic [1:0] ptr, input logic [15:0] w);
      @(negedge clk_sys_i);
      pointer_o = ptr;
      byte_wr_o = 1'b1;
      byte_first_o = 1'b1;
      wr_byte_o = w[15:8];
      @(negedge clk_sys_i);
      byte_first_o = 1'b0;
      wr_byte_o = w[7:0];
      @(negedge clk_sys_i);
      byte_wr_o = 1'b0;
      wr_byte_o = ~w[7:0];
   endtask
   task automatic rd_word(input logic [1:0] ptr, output logic [15:0] w);
      @(negedge clk_sys_i);
      pointer_o = ptr;
      byte_rd_o = 1'b1;
      byte_first_o = 1'b1;
      @(negedge clk_sys_i);
      w[15:8] = rd_byte_i;
      byte_first_o = 1'b0;
      @(negedge clk_sys_i);
      w[7:0] = rd_byte_i;
      byte_rd_o = 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== sim/test_tsca_config_alarm.sv
// Testbench: configuration register and alarm filter
`timescale 1ns/100ps
`default_nettype none
module test_tsca_config_alarm;
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic result_valid_i = 1'b0;
   logic signed [12:0] temp_i = 13'h0000;
   logic signed [12:0] upper_limit_i = 13'h0500;
   logic signed [12:0] lower_limit_i = 13'h04B0;
   logic converting_i = 1'b0;
   logic [1:0] pointer_i;
   logic byte_wr_i;
   logic byte_rd_i;
   logic byte_first_i;
   logic [7:0] wr_byte_i;
   logic [7:0] rd_byte_o;
   logic shutdown_select_o;
   logic convert_start_o;
   logic range_extend_select_o;
   logic output_style_select_o;
   logic alert_o;
   int err_total = 0;
   int n_checks = 0;
   tsca_host_model host (.clk_sys_i(clk_sys_i), .rd_byte_i(rd_byte_o), .pointer_o(pointer_i),
      .byte_wr_o(byte_wr_i), .byte_rd_o(byte_rd_i), .byte_first_o(byte_first_i),
      .wr_byte_o(wr_byte_i));
   tsca_config_alarm dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .pointer_i(pointer_i),
      .byte_wr_i(byte_wr_i), .byte_rd_i(byte_rd_i), .byte_first_i(byte_first_i),
      .wr_byte_i(wr_byte_i), .rd_byte_o(rd_byte_o), .result_valid_i(result_valid_i),
      .temp_i(temp_i), .upper_limit_i(upper_limit_i), .lower_limit_i(lower_limit_i),
      .converting_i(converting_i), .shutdown_select_o(shutdown_select_o),
      .convert_start_o(convert_start_o), .range_extend_select_o(range_extend_select_o),
      .output_style_select_o(output_style_select_o), .alert_o(alert_o));
   initial forever #25 clk_sys_i = ~clk_sys_i;
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic res(input logic [12:0] t);
      @(negedge clk_sys_i);
      result_valid_i = 1'b1;
      temp_i = t;
      @(negedge clk_sys_i);
      result_valid_i = 1'b0;
      temp_i = ~t;
   endtask
   task automatic t_reset;
      logic [15:0] w;
      host.rd_word(2'h1, w);
      chk("reset word", 16'hE0A0, w);
      chk("reset outputs", 16'h0001,
         {13'h0000, shutdown_select_o, range_extend_select_o, alert_o});
      $display("reset test done");
   endtask
   task automatic t_write;
      logic [15:0] w;
      host.wr_word(2'h1, 16'h1FDF);
      host.wr_word(2'h2, 16'h0000);
      // Conversion in progress reads back as a clear top bit
      converting_i = 1'b1;
      host.rd_word(2'h1, w);
      converting_i = 1'b0;
      chk("written word", 16'h7FD0, w);
      chk("selects", 16'h0007, {13'h0000, shutdown_select_o, output_style_select_o,
         range_extend_select_o});
      chk("no start in shutdown", 16'h0000, {15'h0000, convert_start_o});
      chk("alert idle", {15'h0000, alert_o}, 16'h0000);
      $display("write test done");
   endtask
   task automatic t_alarm(input logic [1:0] fc, input logic alert_polarity_select);
      int n;
      logic [15:0] w;
      n = (fc == 2'h0) ? 1 : (fc == 2'h1) ? 2 : (fc == 2'h2) ? 4 : 6;
      host.wr_word(2'h1, {3'h0, fc, alert_polarity_select, fc[0], 1'b0, 8'h80});
      repeat (n - 1) res(13'h0600);
      res(13'h04C0);
      repeat (n - 1) res(13'h0600);
      chk("alert before trip", {15'h0000, alert_o}, {15'h0000, ~alert_polarity_select});
      res(13'h0500);
      chk("alert tripped", {15'h0000, alert_o}, {15'h0000, alert_polarity_select});
      host.rd_word(2'h1, w);
      chk("status tripped", {15'h0000, w[5]}, {15'h0000, alert_polarity_select});
      repeat (n - 1) res(13'h0100);
      res(13'h04B0);
      repeat (n - 1) res(13'h0100);
      chk("alert held", {15'h0000, alert_o}, {15'h0000, alert_polarity_select});
      res(13'h0100);
      chk("alert cleared", {15'h0000, alert_o}, {15'h0000, ~alert_polarity_select});
      $display("alarm test done fault code %0d", fc);
   endtask
   initial
   begin
      #1000000;
      err_total++;
      results();
   end
   initial
   begin
      repeat (2) @(negedge clk_sys_i);
      reset_i = 1'b0;
      t_reset();
      t_write();
      for (int f = 0; f < 4; f++)
         t_alarm(f[1:0], 1'b0);
      t_alarm(2'h1, 1'b1);
      results();
   end
endmodule
`default_nettype wire
